// File: design/chan_cfg_pkg.sv
package chan_cfg_pkg;

    // ------------------------------------------------------------
    // register map, page 0
    // ------------------------------------------------------------
    localparam logic [7:0] REG_PAGE = 8'h00;
    localparam logic [7:0] ADDR_CHAN4_ANALOG_GAIN = 8'h4c;
    localparam logic [7:0] ADDR_CHAN4_DIGITAL_VOLUME = 8'h4d;
    localparam logic [7:0] ADDR_CHAN4_GAIN_TRIM = 8'h4e;
    localparam logic [7:0] ADDR_CHAN4_PHASE_TRIM = 8'h4f;
    localparam logic [7:0] ADDR_CHAN5_DIGITAL_VOLUME = 8'h52;
    localparam logic [7:0] ADDR_CHAN5_GAIN_TRIM = 8'h53;

    // ------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ANALOG_GAIN = 8'h00;
    localparam logic [7:0] RST_DIGITAL_VOLUME = 8'hc9;
    localparam logic [7:0] RST_GAIN_TRIM = 8'h80;
    localparam logic [7:0] RST_PHASE_TRIM = 8'h00;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam int GAIN_CODE_LSB = 2;
    localparam int TRIM_CODE_LSB = 4;
    localparam logic [7:0] MASK_ANALOG_GAIN = 8'hfc;
    localparam logic [7:0] MASK_GAIN_TRIM = 8'hf0;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [7:0] VOL_MUTE_CODE = 8'h00;
    localparam logic [7:0] VOL_UNITY_CODE = 8'hc9;
    localparam logic [3:0] TRIM_UNITY_CODE = 4'h8;
    localparam logic [5:0] GAIN_MAX_CODE = 6'h2a;
    localparam logic [7:0] PHASE_NONE_CODE = 8'h00;
    // volume code plus this offset counts half-dB steps above -108 dB
    localparam logic [8:0] VOL_STEP_OFFSET = 9'h00f;
    localparam logic [8:0] VOL_STEPS_PER_OCTAVE = 9'h00c;
    localparam int VOL_DOWN_SHIFT = 9;
    localparam int TRIM_FRAC = 14;

    // ------------------------------------------------------------
    // gain factor format: unsigned, 24 fraction bits
    // ------------------------------------------------------------
    localparam int FACTOR_W = 30;
    localparam int FACTOR_FRAC = 24;
    localparam logic [29:0] FACTOR_UNITY = 30'h1000000;
    localparam int PIPE_DEPTH = 2;

    typedef enum logic [1:0] {
        SRC_ANALOG_DIFF,
        SRC_ANALOG_SINGLE,
        SRC_DIGITAL_MIC,
        SRC_RESERVED
    } source_t;

endpackage

// File: design/channel_gain_volume_calibration_regs.sv
// What this block does
// - channel 4 analog gain code sits in bits 7..2, 0 to 42 dB
// - gain code resets to zero and the low two bits read zero
// - volume code zero mutes the channel completely
// - volume code 1 is -100 dB, each step adds 0.5 dB
// - volume code 201 is unity and is the volume reset value
// - volume code 255 is +27 dB, 254 is +26.5 dB
// - trim field bits 7..4: code 0 is -0.8 dB, 0.1 dB steps
// - trim code 8 is 0 dB and the register resets to 80h
// - trim code 15 is +0.7 dB; low four bits read zero
// - phase code zero adds no delay and is the reset value
// - phase code N delays channel 4 by N modulator clocks
// - channel 5 volume and trim act only with a digital mic input
// - channel 5 volume uses the channel 4 encoding and reset C9h
// - channel 4 registers start at page 0 address 4Ch, consecutive
// - channel 4 source: analog diff, analog single, digital mic; 3 reserved
`timescale 1ns/1ps
`default_nettype none
module channel_gain_volume_calibration_regs
    import chan_cfg_pkg::*;
#(
    parameter int SAMPLE_W = 24,
    parameter int MOD_W = 4,
    parameter int DELAY_DEPTH = 256
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // control port
    input wire logic [7:0] reg_page,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata,
    // channel 4 source and modulator stream
    input wire logic [1:0] chan4_source_select,
    input wire logic mod_clk_en,
    input wire logic [MOD_W-1:0] chan4_adc_mod,
    input wire logic [MOD_W-1:0] chan4_pdm_mod,
    output logic [MOD_W-1:0] chan4_mod_delayed,
    output logic [5:0] chan4_pga_gain,
    output logic chan4_source_invalid,
    // channel 4 decimated samples
    input wire logic chan4_sample_valid,
    input wire logic signed [SAMPLE_W-1:0] chan4_sample,
    output logic chan4_out_valid,
    output logic signed [SAMPLE_W-1:0] chan4_out,
    // channel 5 decimated samples
    input wire logic chan5_digital_mic,
    input wire logic chan5_sample_valid,
    input wire logic signed [SAMPLE_W-1:0] chan5_sample,
    output logic chan5_out_valid,
    output logic signed [SAMPLE_W-1:0] chan5_out
);

    localparam int PTR_W = $clog2(DELAY_DEPTH);
    localparam int PROD_W = SAMPLE_W + FACTOR_W + 1;

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    generate
        if (SAMPLE_W < 8 || SAMPLE_W > 32) begin : g_bad_sample_w
            $error("SAMPLE_W must lie between 8 and 32");
        end
        if (MOD_W < 1) begin : g_bad_mod_w
            $error("MOD_W must be at least 1");
        end
        if (DELAY_DEPTH < 256 || (1 << PTR_W) != DELAY_DEPTH) begin : g_bad_depth
            $error("DELAY_DEPTH must be a power of two of at least 256");
        end
    endgenerate

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic [7:0] chan4_analog_gain_reg;
    logic [7:0] chan4_digital_volume_reg;
    logic [7:0] chan4_gain_trim_reg;
    logic [7:0] chan4_phase_trim_reg;
    logic [7:0] chan5_digital_volume_reg;
    logic [7:0] chan5_gain_trim_reg;

    wire logic page_hit = (reg_page == REG_PAGE);
    wire logic wr_c4_gain = reg_wr_en && page_hit && reg_addr == ADDR_CHAN4_ANALOG_GAIN;
    wire logic wr_c4_vol = reg_wr_en && page_hit && reg_addr == ADDR_CHAN4_DIGITAL_VOLUME;
    wire logic wr_c4_trim = reg_wr_en && page_hit && reg_addr == ADDR_CHAN4_GAIN_TRIM;
    wire logic wr_c4_phase = reg_wr_en && page_hit && reg_addr == ADDR_CHAN4_PHASE_TRIM;
    wire logic wr_c5_vol = reg_wr_en && page_hit && reg_addr == ADDR_CHAN5_DIGITAL_VOLUME;
    wire logic wr_c5_trim = reg_wr_en && page_hit && reg_addr == ADDR_CHAN5_GAIN_TRIM;

    // reserved bits never reach the flip-flops
    wire logic [7:0] gain_wdata = reg_wdata & MASK_ANALOG_GAIN;
    wire logic [7:0] trim_wdata = reg_wdata & MASK_GAIN_TRIM;

    logic [7:0] read_mux;
    always_comb begin
        read_mux = RST_READ_DATA;
        if (page_hit) begin
            unique case (reg_addr)
                ADDR_CHAN4_ANALOG_GAIN: read_mux = chan4_analog_gain_reg;
                ADDR_CHAN4_DIGITAL_VOLUME: read_mux = chan4_digital_volume_reg;
                ADDR_CHAN4_GAIN_TRIM: read_mux = chan4_gain_trim_reg;
                ADDR_CHAN4_PHASE_TRIM: read_mux = chan4_phase_trim_reg;
                ADDR_CHAN5_DIGITAL_VOLUME: read_mux = chan5_digital_volume_reg;
                ADDR_CHAN5_GAIN_TRIM: read_mux = chan5_gain_trim_reg;
                default: read_mux = RST_READ_DATA;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            chan4_analog_gain_reg <= RST_ANALOG_GAIN;
            chan4_digital_volume_reg <= RST_DIGITAL_VOLUME;
            chan4_gain_trim_reg <= RST_GAIN_TRIM;
            chan4_phase_trim_reg <= RST_PHASE_TRIM;
            chan5_digital_volume_reg <= RST_DIGITAL_VOLUME;
            chan5_gain_trim_reg <= RST_GAIN_TRIM;
        end else begin
            if (wr_c4_gain) chan4_analog_gain_reg <= gain_wdata;
            if (wr_c4_vol) chan4_digital_volume_reg <= reg_wdata;
            if (wr_c4_trim) chan4_gain_trim_reg <= trim_wdata;
            if (wr_c4_phase) chan4_phase_trim_reg <= reg_wdata;
            if (wr_c5_vol) chan5_digital_volume_reg <= reg_wdata;
            if (wr_c5_trim) chan5_gain_trim_reg <= trim_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reg_rdata <= RST_READ_DATA;
        end else if (reg_rd_en) begin
            reg_rdata <= read_mux;
        end
    end

    // ------------------------------------------------------------
    // channel 4 source selection and analog gain
    // ------------------------------------------------------------
    wire source_t chan4_source = source_t'(chan4_source_select);
    wire logic chan4_is_analog = chan4_source == SRC_ANALOG_DIFF ||
        chan4_source == SRC_ANALOG_SINGLE;
    wire logic [5:0] chan4_gain_code = chan4_analog_gain_reg[GAIN_CODE_LSB+5:GAIN_CODE_LSB];
    // reserved gain codes are passed on as written; software keeps them out
    wire logic [5:0] pga_gain_next = chan4_is_analog ? chan4_gain_code : 6'h00;
    wire logic [MOD_W-1:0] chan4_mod_in =
        (chan4_source == SRC_DIGITAL_MIC) ? chan4_pdm_mod :
        chan4_is_analog ? chan4_adc_mod : '0;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            chan4_pga_gain <= 6'h00;
            chan4_source_invalid <= 1'b0;
        end else begin
            chan4_pga_gain <= pga_gain_next;
            chan4_source_invalid <= chan4_source == SRC_RESERVED;
        end
    end

    // ------------------------------------------------------------
    // channel 4 phase delay on the modulator stream
    // ------------------------------------------------------------
    logic [MOD_W-1:0] delay_mem [DELAY_DEPTH];
    logic [PTR_W-1:0] delay_wr_ptr_reg;
    wire logic [7:0] chan4_phase_delay_code = chan4_phase_trim_reg;
    wire logic [PTR_W-1:0] delay_rd_ptr =
        delay_wr_ptr_reg - PTR_W'(chan4_phase_delay_code);
    wire logic [MOD_W-1:0] delayed_next =
        (chan4_phase_delay_code == PHASE_NONE_CODE) ? chan4_mod_in :
        delay_mem[delay_rd_ptr];

    always_ff @(posedge sys_clk) begin
        if (mod_clk_en) begin
            delay_mem[delay_wr_ptr_reg] <= chan4_mod_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            delay_wr_ptr_reg <= '0;
            chan4_mod_delayed <= '0;
        end else if (mod_clk_en) begin
            delay_wr_ptr_reg <= delay_wr_ptr_reg + PTR_W'(1);
            chan4_mod_delayed <= delayed_next;
        end
    end

    // ------------------------------------------------------------
    // volume and trim factors
    // ------------------------------------------------------------
    logic [FACTOR_W-1:0] chan4_factor;
    logic [FACTOR_W-1:0] chan5_factor;
    wire logic [7:0] chan4_volume_code = chan4_digital_volume_reg;
    wire logic [3:0] chan4_gain_trim_code = chan4_gain_trim_reg[TRIM_CODE_LSB+3:TRIM_CODE_LSB];
    wire logic [7:0] chan5_volume_code = chan5_digital_volume_reg;
    wire logic [3:0] chan5_gain_trim_code = chan5_gain_trim_reg[TRIM_CODE_LSB+3:TRIM_CODE_LSB];

    volume_factor_lut u_chan4_factor (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .volume_code(chan4_volume_code),
        .trim_code(chan4_gain_trim_code),
        .bypass(1'b0),
        .factor(chan4_factor)
    );

    // channel 5 passes at unity unless it carries a digital microphone
    volume_factor_lut u_chan5_factor (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .volume_code(chan5_volume_code),
        .trim_code(chan5_gain_trim_code),
        .bypass(!chan5_digital_mic),
        .factor(chan5_factor)
    );

    // ------------------------------------------------------------
    // sample scaling, two stages per channel
    // ------------------------------------------------------------
    logic [1:0] in_valid;
    logic signed [SAMPLE_W-1:0] in_sample [2];
    logic [FACTOR_W-1:0] in_factor [2];
    logic out_valid_reg [2];
    logic signed [SAMPLE_W-1:0] out_sample_reg [2];

    assign in_valid = {chan5_sample_valid, chan4_sample_valid};
    assign in_sample[0] = chan4_sample;
    assign in_sample[1] = chan5_sample;
    assign in_factor[0] = chan4_factor;
    assign in_factor[1] = chan5_factor;

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_scale
            logic signed [PROD_W-1:0] prod_reg;
            logic prod_valid_reg;
            wire logic signed [PROD_W-1:0] prod_next =
                in_sample[ch] * $signed({1'b0, in_factor[ch]});
            wire logic signed [PROD_W-1:0] prod_shifted = prod_reg >>> FACTOR_FRAC;
            wire logic signed [PROD_W-1:0] sat_hi = PROD_W'((1 << (SAMPLE_W - 1)) - 1);
            wire logic signed [PROD_W-1:0] sat_lo = -PROD_W'(1 << (SAMPLE_W - 1));
            wire logic signed [SAMPLE_W-1:0] sat_next =
                (prod_shifted > sat_hi) ? sat_hi[SAMPLE_W-1:0] :
                (prod_shifted < sat_lo) ? sat_lo[SAMPLE_W-1:0] :
                prod_shifted[SAMPLE_W-1:0];

            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    prod_reg <= '0;
                    prod_valid_reg <= 1'b0;
                    out_sample_reg[ch] <= '0;
                    out_valid_reg[ch] <= 1'b0;
                end else begin
                    prod_valid_reg <= in_valid[ch];
                    out_valid_reg[ch] <= prod_valid_reg;
                    if (in_valid[ch]) prod_reg <= prod_next;
                    if (prod_valid_reg) out_sample_reg[ch] <= sat_next;
                end
            end
        end
    endgenerate

    assign chan4_out_valid = out_valid_reg[0];
    assign chan4_out = out_sample_reg[0];
    assign chan5_out_valid = out_valid_reg[1];
    assign chan5_out = out_sample_reg[1];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [MOD_W-1:0] last_mod_in_reg;
    logic mod_seen_reg;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            last_mod_in_reg <= '0;
            mod_seen_reg <= 1'b0;
        end else if (mod_clk_en) begin
            last_mod_in_reg <= chan4_mod_in;
            mod_seen_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_gain_low_zero:
        assert property (chan4_analog_gain_reg[GAIN_CODE_LSB-1:0] == 2'b00)
        else $error("reserved gain bits are not zero");
    chk_trim_low_zero:
        assert property (chan4_gain_trim_reg[TRIM_CODE_LSB-1:0] == 4'h0 &&
            chan5_gain_trim_reg[TRIM_CODE_LSB-1:0] == 4'h0)
        else $error("reserved trim bits are not zero");
    chk_gain_write_read:
        assert property (wr_c4_gain ##1 (reg_rd_en && page_hit &&
            reg_addr == ADDR_CHAN4_ANALOG_GAIN && !reg_wr_en) |=>
            reg_rdata == ($past(reg_wdata, 2) & MASK_ANALOG_GAIN))
        else $error("gain register did not read back its written code");
    // reset is the antecedent here, so the default disable must not apply
    chk_reset_values:
        assert property (@(posedge sys_clk) disable iff (1'b0) !rst_b |=>
            chan4_gain_trim_reg == RST_GAIN_TRIM && chan5_gain_trim_reg == RST_GAIN_TRIM &&
            chan4_digital_volume_reg == RST_DIGITAL_VOLUME &&
            chan5_digital_volume_reg == RST_DIGITAL_VOLUME &&
            chan4_analog_gain_reg == RST_ANALOG_GAIN && chan4_phase_trim_reg == RST_PHASE_TRIM)
        else $error("registers did not take their reset values");
    chk_phase_zero_pass:
        assert property (mod_clk_en && chan4_phase_delay_code == PHASE_NONE_CODE |=>
            chan4_mod_delayed == $past(chan4_mod_in))
        else $error("zero phase code delayed the stream");
    chk_phase_one_delay:
        assert property (mod_clk_en && mod_seen_reg && chan4_phase_delay_code == 8'h01 |=>
            chan4_mod_delayed == $past(last_mod_in_reg))
        else $error("phase code one did not delay by one modulator clock");
    chk_source_pga:
        assert property (!chan4_is_analog |=> chan4_pga_gain == 6'h00)
        else $error("analog gain applied to a non-analog source");

    chk_source_flag:
        assert property (chan4_source_select == 2'h3 |=> chan4_source_invalid)
        else $error("reserved source select did not raise the flag");

    chk_rdata_hold:
        assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    chk_scale_latency:
        assert property (chan4_sample_valid |-> ##2 chan4_out_valid)
        else $error("scaled sample did not appear two cycles later");
    chk_mute_output:
        assert property (chan4_sample_valid && chan4_factor == '0 && $stable(chan4_factor)
            |-> ##2 chan4_out == '0)
        else $error("muted channel produced a nonzero sample");
    chk_unmapped_read:
        assert property (reg_rd_en && !page_hit |=> reg_rdata == RST_READ_DATA)
        else $error("read outside page 0 returned data");

endmodule // channel_gain_volume_calibration_regs
`default_nettype wire

// File: design/volume_factor_lut.sv
`timescale 1ns/1ps
`default_nettype none
module volume_factor_lut
    import chan_cfg_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // settings
    input wire logic [7:0] volume_code,
    input wire logic [3:0] trim_code,
    input wire logic bypass,
    // linear factor
    output logic [FACTOR_W-1:0] factor
);

    // ------------------------------------------------------------
    // tables: half-dB mantissa in Q15, trim in Q14
    // ------------------------------------------------------------
    function automatic logic [15:0] vol_mantissa(input logic [3:0] idx);
        unique case (idx)
            4'h0: vol_mantissa = 16'h8000;
            4'h1: vol_mantissa = 16'h8796;
            4'h2: vol_mantissa = 16'h8f9e;
            4'h3: vol_mantissa = 16'h9821;
            4'h4: vol_mantissa = 16'ha125;
            4'h5: vol_mantissa = 16'haab1;
            4'h6: vol_mantissa = 16'hb4ce;
            4'h7: vol_mantissa = 16'hbf85;
            4'h8: vol_mantissa = 16'hcade;
            4'h9: vol_mantissa = 16'hd6e3;
            4'ha: vol_mantissa = 16'he39f;
            4'hb: vol_mantissa = 16'hf11c;
            default: vol_mantissa = 16'h0000;
        endcase
    endfunction

    function automatic logic [14:0] trim_factor(input logic [3:0] code);
        unique case (code)
            4'h0: trim_factor = 15'h3a5e;
            4'h1: trim_factor = 15'h3b0b;
            4'h2: trim_factor = 15'h3bba;
            4'h3: trim_factor = 15'h3c6b;
            4'h4: trim_factor = 15'h3d1e;
            4'h5: trim_factor = 15'h3dd4;
            4'h6: trim_factor = 15'h3e8b;
            4'h7: trim_factor = 15'h3f44;
            4'h8: trim_factor = 15'h4000;
            4'h9: trim_factor = 15'h40be;
            4'ha: trim_factor = 15'h417e;
            4'hb: trim_factor = 15'h4240;
            4'hc: trim_factor = 15'h4304;
            4'hd: trim_factor = 15'h43cb;
            4'he: trim_factor = 15'h4494;
            4'hf: trim_factor = 15'h455f;
        endcase
    endfunction

    // ------------------------------------------------------------
    // volume: code 1 = -100 dB, 0.5 dB per code, 201 = 0 dB
    // ------------------------------------------------------------
    wire logic [8:0] vol_steps = {1'b0, volume_code} + VOL_STEP_OFFSET;
    wire logic [8:0] vol_octave = vol_steps / VOL_STEPS_PER_OCTAVE;
    wire logic [8:0] vol_index = vol_steps % VOL_STEPS_PER_OCTAVE;
    wire logic [37:0] vol_shifted = {22'h000000, vol_mantissa(vol_index[3:0])} << vol_octave[4:0];
    wire logic [28:0] vol_linear = vol_shifted[VOL_DOWN_SHIFT+28:VOL_DOWN_SHIFT];
    wire logic [43:0] vol_trimmed = vol_linear * trim_factor(trim_code);
    wire logic [FACTOR_W-1:0] factor_next = bypass ? FACTOR_UNITY :
        (volume_code == VOL_MUTE_CODE) ? '0 :
        vol_trimmed[TRIM_FRAC+FACTOR_W-1:TRIM_FRAC];

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            factor <= FACTOR_UNITY;
        end else begin
            factor <= factor_next;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_mute_zero:
        assert property (!bypass && volume_code == VOL_MUTE_CODE |=> factor == '0)
        else $error("muted volume code left a nonzero factor");
    chk_unity_volume:
        assert property (!bypass && volume_code == VOL_UNITY_CODE &&
            trim_code == TRIM_UNITY_CODE |=> factor == FACTOR_UNITY)
        else $error("unity volume and trim did not give unity factor");
    chk_bypass_unity:
        assert property (bypass |=> factor == FACTOR_UNITY)
        else $error("bypassed channel did not pass at unity");
    chk_volume_rises:
        assert property (!bypass && volume_code != VOL_MUTE_CODE && $stable(trim_code) &&
            volume_code == $past(volume_code) + 8'h01 && !$past(bypass) |=>
            factor > $past(factor))
        else $error("one volume step up did not raise the factor");

endmodule // volume_factor_lut
`default_nettype wire

// File: test/channel_gain_volume_calibration_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module channel_gain_volume_calibration_regs_tb
    import chan_cfg_pkg::*;
;
logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0, mod_clk_en = 1'b0;
logic v4 = 1'b0, v5 = 1'b0, mic = 1'b0, invalid, o4v, o5v;
logic [7:0] reg_page = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
logic [1:0] src = 2'h0;
logic [3:0] adc = 4'h0, pdm = 4'hc, mod_out;
logic [5:0] pga;
logic signed [23:0] s4 = 24'sh0, s5 = 24'sh0, o4, o5;
int fails = 0, checked = 0, cycles = 0;
always #50 sys_clk = ~sys_clk;
channel_gain_volume_calibration_regs u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .chan4_source_select(src),
    .mod_clk_en(mod_clk_en), .chan4_adc_mod(adc), .chan4_pdm_mod(pdm),
    .chan4_mod_delayed(mod_out), .chan4_pga_gain(pga), .chan4_source_invalid(invalid),
    .chan4_sample_valid(v4), .chan4_sample(s4), .chan4_out_valid(o4v), .chan4_out(o4),
    .chan5_digital_mic(mic), .chan5_sample_valid(v5), .chan5_sample(s5),
    .chan5_out_valid(o5v), .chan5_out(o5));
// ------------------------------------------------------------
// drivers and compare
// ------------------------------------------------------------
task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
        fails++;
        $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk) {reg_addr, reg_wdata, reg_wr_en} = {a, d, 1'b1};
    @(negedge sys_clk) reg_wr_en = 1'b0;
    repeat (2) @(negedge sys_clk);
endtask
task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string n);
    @(negedge sys_clk) {reg_addr, reg_rd_en} = {a, 1'b1};
    @(negedge sys_clk) reg_rd_en = 1'b0;
    @(negedge sys_clk) chk(n, {16'h0, reg_rdata}, {16'h0, exp});
endtask
task automatic smp(input logic ch, input logic [23:0] x, input logic [23:0] exp, input string n);
    @(negedge sys_clk) if (ch) {v5, s5} = {1'b1, x}; else {v4, s4} = {1'b1, x};
    @(negedge sys_clk) {v4, v5} = 2'b00;
    @(negedge sys_clk) chk("out valid", {23'h0, ch ? o5v : o4v}, 24'h1);
    chk(n, ch ? o5 : o4, exp);
endtask
task automatic tick(input logic [3:0] v, input logic [3:0] exp, input logic cmp);
    @(negedge sys_clk) {adc, mod_clk_en} = {v, 1'b1};
    @(negedge sys_clk) mod_clk_en = 1'b0;
    if (cmp) chk("mod delayed", {20'h0, mod_out}, {20'h0, exp});
endtask
// ------------------------------------------------------------
// scenarios
// ------------------------------------------------------------
task automatic t_reset;
    rdc(ADDR_CHAN4_ANALOG_GAIN, 8'h00, "gain rst");
    rdc(ADDR_CHAN4_DIGITAL_VOLUME, 8'hc9, "vol rst");
    rdc(ADDR_CHAN4_GAIN_TRIM, 8'h80, "trim rst");
    rdc(ADDR_CHAN4_PHASE_TRIM, 8'h00, "phase rst");
    rdc(ADDR_CHAN5_DIGITAL_VOLUME, 8'hc9, "vol5 rst");
    rdc(ADDR_CHAN5_GAIN_TRIM, 8'h80, "trim5 rst");
    $display("test reset values done");
endtask
task automatic t_access;
    wr(8'h4c, 8'hab);
    rdc(8'h4c, 8'ha8, "gain bits");
    wr(8'h4e, 8'hff);
    rdc(8'h4e, 8'hf0, "trim bits");
    wr(8'h53, 8'hff);
    rdc(8'h53, 8'hf0, "trim5 bits");
    reg_page = 8'h01;
    wr(8'h4d, 8'h00);
    rdc(8'h4d, 8'h00, "other page");
    reg_page = 8'h00;
    rdc(8'h4d, 8'hc9, "page 0 kept");
    rdc(8'h50, 8'h00, "unmapped");
    wr(8'h4e, 8'h80);
    wr(8'h53, 8'h80);
    @(negedge sys_clk) {reg_addr, reg_wdata, reg_wr_en} = {8'h4c, 8'h57, 1'b1};
    @(negedge sys_clk) {reg_wr_en, reg_rd_en} = 2'b01;
    @(negedge sys_clk) reg_rd_en = 1'b0;
    chk("gain back to back", {16'h0, reg_rdata}, 24'h000054);
    $display("test access done");
endtask
task automatic t_path;
    smp(1'b0, 24'h001234, 24'h001234, "unity");
    wr(8'h4d, 8'h00);
    smp(1'b0, 24'h001234, 24'h000000, "mute");
    wr(8'h4d, 8'h01);
    wr(8'h4d, 8'h02);
    wr(8'h4d, 8'hc9);
    wr(8'h52, 8'h00);
    smp(1'b1, 24'hff0000, 24'hff0000, "ch5 not mic");
    @(negedge sys_clk) mic = 1'b1;
    repeat (3) @(negedge sys_clk);
    smp(1'b1, 24'hff0000, 24'h000000, "ch5 mic mute");
    $display("test sample path done");
endtask
task automatic t_phase;
    tick(4'h5, 4'h5, 1'b1);
    wr(8'h4f, 8'h02);
    for (int k = 1; k < 7; k++) tick(4'(k), 4'(k - 2), k > 2);
    wr(8'h4f, 8'h01);
    tick(4'h9, 4'h6, 1'b1);
    $display("test phase done");
endtask
task automatic t_source;
    wr(8'h4c, 8'ha8);
    wr(8'h4f, 8'h00);
    for (int s = 0; s < 4; s++) begin
        @(negedge sys_clk) src = 2'(s);
        @(negedge sys_clk) chk("pga gain", {18'h0, pga}, (s < 2) ? 24'h2a : 24'h0);
        chk("source invalid", {23'h0, invalid}, {23'h0, s == 3});
        tick(4'h3, (s < 2) ? 4'h3 : (s == 2) ? 4'hc : 4'h0, 1'b1);
    end
    $display("test source done");
endtask
task automatic print_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
        fails++;
        print_verdict();
    end
end
initial begin
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    t_reset();
    t_access();
    t_path();
    t_phase();
    t_source();
    print_verdict();
end
endmodule // channel_gain_volume_calibration_regs_tb
`default_nettype wire
